// >>> sync_serial_map.vh
// Register map, field positions, reset values and timing counts of the serial port
`ifndef SYNC_SERIAL_MAP_VH
`define SYNC_SERIAL_MAP_VH
// -----------------------------------------------------------------
// Byte addresses (word aligned)
// -----------------------------------------------------------------
`define ADDR_CONTROL 8'h14
`define ADDR_BUFFER 8'h18
`define ADDR_IRQ_STATUS 8'h1C
`define ADDR_IRQ_MASK 8'h20
// -----------------------------------------------------------------
// Control register fields
// -----------------------------------------------------------------
`define BIT_COLLIDE 7
`define BIT_ROVF 6
`define BIT_EN 5
`define BIT_CPOL 4
`define RESET_CONTROL 8'h00
// Mode encodings
`define MODE_M4 4'h0
`define MODE_M16 4'h1
`define MODE_M64 4'h2
`define MODE_SLAVE_SS 4'h4
`define MODE_SLAVE 4'h5
// Half-period counts of the master clock in system clocks
`define HALF_DIV4 7'd2
`define HALF_DIV16 7'd8
`define HALF_DIV64 7'd32
// Interrupt status bits
`define IRQ_DONE 0
`define IRQ_COLLIDE 1
`define IRQ_ROVF 2
`endif

// >>> sync_in.v
// Three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/1ps
`default_nettype none
module sync_in (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Pin side
   input wire pinIn,
   // Filtered level
   output reg level
);
   reg s1_ff;
   reg s2_ff;
   reg s3_ff;

   // First stage feeds only the second; level moves once stages two and three agree
   always @(posedge clock) begin
      if (!rst_n) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         level <= 1'b0;
      end else begin
         s1_ff <= pinIn;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         if (s2_ff == s3_ff) begin
            level <= s3_ff;
         end
      end
   end
endmodule // sync_in
`default_nettype wire

// >>> sync_serial_spi_control.v
// SPI master/slave serial port with control register on AHB-Lite
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_map.vh"
module sync_serial_spi_control (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire [31:0] hrdata,
   output wire hreadyout,
   output wire hresp,
   // Serial clock pin
   input wire sckIn,
   output reg sckOut,
   output reg sckOe,
   // Data pins
   input wire sdiIn,
   output reg sdoOut,
   output reg sdoOe,
   input wire ssN,
   // Interrupt
   output wire irq
);
   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   reg [7:0] ctrl_ff;
   reg [7:0] buf_ff;
   reg bufFull_ff;
   reg [7:0] shift_ff;
   reg [3:0] bitCnt_ff;
   reg busy_ff;
   reg [6:0] div_ff;
   reg sckInt_ff;
   reg sckPrev_ff;
   reg [2:0] irqSt_ff;
   reg [2:0] irqMask_ff;
   reg wrPend_ff;
   reg rdPend_ff;
   reg [7:0] addr_ff;
   reg [31:0] rdata_ff;

   wire sckSync;
   wire sdiSync;
   wire ssSync;
   wire [3:0] mode = ctrl_ff[3:0];
   wire enable = ctrl_ff[`BIT_EN];
   wire cpol = ctrl_ff[`BIT_CPOL];

   // Master when mode decodes to one of the divided clocks
   function isMaster;
      input [3:0] m;
      begin
         isMaster = (m == `MODE_M4) || (m == `MODE_M16) || (m == `MODE_M64);
      end
   endfunction

   // Half-period select per mode
   function [6:0] halfCount;
      input [3:0] m;
      begin
         case (m)
            `MODE_M64: halfCount = `HALF_DIV64;
            `MODE_M16: halfCount = `HALF_DIV16;
            default: halfCount = `HALF_DIV4;
         endcase
      end
   endfunction

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   sync_in uSck (.clock(clock), .rst_n(rst_n), .pinIn(sckIn), .level(sckSync));
   sync_in uSdi (.clock(clock), .rst_n(rst_n), .pinIn(sdiIn), .level(sdiSync));
   sync_in uSs (.clock(clock), .rst_n(rst_n), .pinIn(ssN), .level(ssSync));

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   wire master = isMaster(mode);
   wire slaveSs = (mode == `MODE_SLAVE_SS);
   wire slaveMode = slaveSs || (mode == `MODE_SLAVE);
   wire addrPhase = hsel && hready && htrans[1];
   wire bufWrite = wrPend_ff && (addr_ff == `ADDR_BUFFER);
   wire bufRead = rdPend_ff && (addr_ff == `ADDR_BUFFER);
   wire ctrlWrite = wrPend_ff && (addr_ff == `ADDR_CONTROL);

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_ff;
   assign irq = |(irqSt_ff & irqMask_ff);

   // -----------------------------------------------------------------
   // Edge events of the serial clock
   // -----------------------------------------------------------------
   // Slave ignores the clock while its select pin is high in select mode
   wire slaveActive = enable && slaveMode && !(slaveSs && ssSync);
   wire linkClk = master ? sckInt_ff : sckSync;
   wire leading = (linkClk != sckPrev_ff) && (linkClk != cpol);
   wire trailing = (linkClk != sckPrev_ff) && (linkClk == cpol);
   wire shiftOn = master ? busy_ff : slaveActive;
   wire byteDone = shiftOn && trailing && (bitCnt_ff == 4'd7);
   // Collision: buffer written while a word is shifting
   wire collide = bufWrite && enable && (master ? busy_ff : (bitCnt_ff != 4'd0));
   // Overflow only in slave operation, never master
   wire overflow = byteDone && !master && bufFull_ff;

   // Address phase capture; read data registered for the data phase
   always @(posedge clock) begin
      if (!rst_n) begin
         wrPend_ff <= 1'b0;
         rdPend_ff <= 1'b0;
         addr_ff <= 8'h00;
         rdata_ff <= 32'h00000000;
      end else begin
         wrPend_ff <= addrPhase && hwrite;
         rdPend_ff <= addrPhase && !hwrite;
         addr_ff <= haddr[7:0];
         if (addrPhase && !hwrite) begin
            case (haddr[7:0])
               `ADDR_CONTROL: rdata_ff <= {24'h000000, ctrl_ff};
               `ADDR_BUFFER: rdata_ff <= {24'h000000, buf_ff};
               `ADDR_IRQ_STATUS: rdata_ff <= {29'h00000000, irqSt_ff};
               `ADDR_IRQ_MASK: rdata_ff <= {29'h00000000, irqMask_ff};
               default: rdata_ff <= 32'h00000000;
            endcase
         end
      end
   end

   // Control register; hardware sets of the flags win over software clears
   always @(posedge clock) begin
      if (!rst_n) begin
         ctrl_ff <= `RESET_CONTROL;
      end else begin
         if (ctrlWrite) begin
            ctrl_ff <= hwdata[7:0];
         end
         if (collide) begin
            ctrl_ff[`BIT_COLLIDE] <= 1'b1;
         end
         if (overflow) begin
            ctrl_ff[`BIT_ROVF] <= 1'b1;
         end
      end
   end

   // Interrupt status (write one to clear, set wins) and mask
   always @(posedge clock) begin
      if (!rst_n) begin
         irqSt_ff <= 3'h0;
         irqMask_ff <= 3'h0;
      end else begin
         irqSt_ff <= (irqSt_ff & ~((wrPend_ff && addr_ff == `ADDR_IRQ_STATUS)
                     ? hwdata[2:0] : 3'h0)) | {overflow, collide, byteDone && !overflow};
         if (wrPend_ff && addr_ff == `ADDR_IRQ_MASK) begin
            irqMask_ff <= hwdata[2:0];
         end
      end
   end

   // -----------------------------------------------------------------
   // Shift engine and clock generator
   // -----------------------------------------------------------------
   // Master starts on a buffer write only; a colliding write is dropped
   always @(posedge clock) begin
      if (!rst_n) begin
         buf_ff <= 8'h00;
         bufFull_ff <= 1'b0;
         shift_ff <= 8'h00;
         bitCnt_ff <= 4'd0;
         busy_ff <= 1'b0;
         div_ff <= 7'd0;
         sckInt_ff <= 1'b0;
         sckPrev_ff <= 1'b0;
      end else if (!enable) begin
         bitCnt_ff <= 4'd0;
         busy_ff <= 1'b0;
         sckInt_ff <= cpol;
         sckPrev_ff <= master ? cpol : sckSync;
         bufFull_ff <= 1'b0;
      end else begin
         sckPrev_ff <= linkClk;
         if (bufRead) begin
            bufFull_ff <= 1'b0;
         end
         if (bufWrite && !collide) begin
            shift_ff <= hwdata[7:0];
            busy_ff <= master;
            bitCnt_ff <= 4'd0;
            div_ff <= 7'd0;
         end else begin
            // Master divider toggles the clock at the mode's half period
            if (busy_ff) begin
               if (div_ff == halfCount(mode) - 7'd1) begin
                  div_ff <= 7'd0;
                  sckInt_ff <= ~sckInt_ff;
               end else begin
                  div_ff <= div_ff + 7'd1;
               end
            end else begin
               sckInt_ff <= cpol;
            end
            if (shiftOn && leading) begin
               shift_ff <= {shift_ff[6:0], sdiSync};
            end
            if (shiftOn && trailing) begin
               bitCnt_ff <= byteDone ? 4'd0 : bitCnt_ff + 4'd1;
               if (byteDone) begin
                  busy_ff <= 1'b0;
                  if (!overflow) begin
                     buf_ff <= shift_ff; // New byte lost on overflow
                     bufFull_ff <= 1'b1;
                  end
               end
            end
            // Deselect ends a cut frame so the next one starts at bit zero
            if (slaveSs && ssSync) begin
               bitCnt_ff <= 4'd0;
            end
         end
      end
   end

   // Pin drivers: disabled port releases every pin to general use
   always @(posedge clock) begin
      if (!rst_n) begin
         sckOut <= 1'b0;
         sckOe <= 1'b0;
         sdoOut <= 1'b0;
         sdoOe <= 1'b0;
      end else begin
         // Idle level straight from the polarity bit; the divider lags it by a cycle
         sckOut <= (master && busy_ff) ? sckInt_ff : cpol;
         sckOe <= enable && master;
         sdoOut <= shift_ff[7];
         sdoOe <= enable && (master || slaveActive);
      end
   end
endmodule // sync_serial_spi_control
`default_nettype wire

// >>> spi_ctl_asserts.sv
// Checker of bus answers, pin enables and serial clock rate
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_map.vh"
module spi_ctl_asserts (
   // Clock and reset
   input wire clock,
   input wire rst_n,
   // Bus
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire [31:0] hrdata,
   input wire hreadyout,
   input wire hresp,
   // Pins
   input wire sckOut,
   input wire sckOe,
   input wire sdoOe
);
   reg [7:0] ctl_ff;
   reg wr_ff;
   reg rd_ff;
   reg [6:0] gap_ff;
   wire take = hsel && htrans[1] && hreadyout && haddr == {24'h000000, `ADDR_CONTROL};
   wire [6:0] half = ctl_ff[1] ? `HALF_DIV64 : ctl_ff[0] ? `HALF_DIV16 : `HALF_DIV4;
   // Shadow of control fields; gap saturates so long idle never wraps
   always @(posedge clock) begin
      wr_ff <= rst_n && take && hwrite;
      rd_ff <= rst_n && take && !hwrite;
      ctl_ff <= !rst_n ? 8'h00 : wr_ff ? hwdata[7:0] : ctl_ff;
      gap_ff <= (!rst_n || $changed(sckOut)) ? 7'h00 : gap_ff + {6'h00, gap_ff != 7'h7F};
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Control write landing with a given enable and mode range
   sequence ctlWr(en, lo, hi);
      wr_ff && hwdata[`BIT_EN] == en && hwdata[3:0] >= lo && hwdata[3:0] <= hi;
   endsequence
   AST_OKAY: assert property (hreadyout && !hresp)
      else $error("bus answer not OKAY");
   AST_OFF: assert property (ctlWr(1'h0, 4'h0, 4'hF) |-> ##[1:3] !sckOe && !sdoOe)
      else $error("pins kept after disable");
   AST_MST: assert property (ctlWr(1'h1, 4'h1, 4'h2) |-> ##[1:3] sckOe)
      else $error("master did not take clock pin");
   AST_SLV: assert property (ctlWr(1'h1, 4'h4, 4'h5) |-> ##[1:3] !sckOe)
      else $error("slave drove clock pin");
   AST_IDLE: assert property ($rose(sckOe) |-> sckOut == ctl_ff[`BIT_CPOL])
      else $error("idle clock level wrong");
   AST_RATE: assert property ($changed(sckOut) && $past(sckOe, 3)
      |-> gap_ff >= half - 7'h01)
      else $error("serial clock too fast");
   AST_NOOV: assert property (rd_ff && ctl_ff[3:2] == 2'h0 |-> !hrdata[`BIT_ROVF])
      else $error("overflow flag in master mode");
endmodule // spi_ctl_asserts
bind sync_serial_spi_control spi_ctl_asserts chk (.clock(clock), .rst_n(rst_n), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .sckOut(sckOut), .sckOe(sckOe), .sdoOe(sdoOe));
`default_nettype wire

// >>> spi_peer.sv
// Serial peer model: answers the port as master, drives it as slave
`timescale 1ns/1ps
`default_nettype none
module spi_peer (
   // Port pins
   input wire sckOut,
   input wire sckOe,
   input wire sdoOut,
   output logic sckIn,
   output logic sdiIn,
   output logic ssN
);
   logic [7:0] txByte = 8'h00;
   logic [7:0] rxByte = 8'h00;
   int edges = 0;
   int gapNs = 0;
   realtime lastT = 0;
   initial begin
      sckIn = 1'h0;
      sdiIn = 1'h1;
      ssN = 1'h1;
   end
   // Odd edges sample, even edges present next bit; spent line shows no stale bit
   always @(sckOut) begin
      if (sckOe) begin
         gapNs = int'($realtime - lastT);
         lastT = $realtime;
         edges++;
         if (edges[0]) rxByte = {rxByte[6:0], sdoOut};
         else sdiIn = (edges < 16) ? txByte[7 - edges / 2] : ~sdiIn;
      end
   end
   task automatic start;
      edges = 0;
      sdiIn = txByte[7];
   endtask
   // Link clock runs only inside the frame
   // Select low when sel is set; a frame with sel clear must be ignored in select mode
   task automatic sendByte(input logic [7:0] v, input logic sel);
      #13 ssN = ~sel;
      for (int i = 7; i >= 0; i--) begin
         sdiIn = v[i];
         #160 sckIn = 1'h1;
         #160 sckIn = 1'h0;
      end
      #160 ssN = 1'h1;
      sdiIn = ~v[0];
   endtask
endmodule // spi_peer
`default_nettype wire

// >>> sync_serial_spi_control_tb.sv
// Self-checking bench of the serial port control block
`timescale 1ns/1ps
`default_nettype none
`include "sync_serial_map.vh"
module sync_serial_spi_control_tb;
   logic clock = 0;
   logic rst_n = 0;
   logic hsel = 0;
   logic [31:0] haddr = 0;
   logic [1:0] htrans = 0;
   logic hwrite = 0;
   logic [31:0] hwdata = 0;
   logic rdPh = 0;
   logic [7:0] b;
   logic [7:0] ctl;
   logic [31:0] expQ[$];
   int n_fail = 0;
   int compares = 0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, sckOut, sckOe, sdoOut, sdoOe, irq, sckIn, sdiIn, ssN;
   sync_serial_spi_control dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sckIn(sckIn), .sckOut(sckOut),
      .sckOe(sckOe), .sdiIn(sdiIn), .sdoOut(sdoOut), .sdoOe(sdoOe), .ssN(ssN), .irq(irq));
   spi_peer peer (.sckOut(sckOut), .sckOe(sckOe), .sdoOut(sdoOut), .sckIn(sckIn),
      .sdiIn(sdiIn), .ssN(ssN));
   initial forever #20 clock = ~clock;
   task automatic test_done;
      if (n_fail == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Bounded wait on ready or on the interrupt; a hang ends the run
   task automatic waitHi(input logic irqSel);
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while ((irqSel ? irq : hreadyout) !== 1'h1 && n < 3000);
      if (n >= 3000) begin
         n_fail++;
         test_done();
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'h1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      waitHi(1'h0);
      htrans <= 2'h0;
      hwdata <= d;
      rdPh <= !w;
      waitHi(1'h0);
      rdPh <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back(e);
      bus(a, 1'h0, 32'h0);
   endtask
   // Read data is matched against the oldest note
   always @(posedge clock) begin
      if (rdPh && hreadyout && expQ.size() > 0) cmp(hrdata, expQ.pop_front());
   end
   initial begin
      void'($urandom(32'hF558));
      repeat (4) @(posedge clock);
      rst_n <= 1'h1;
      rd(`ADDR_CONTROL, 32'h0);
      rd(8'h24, 32'h0);
      bus(`ADDR_IRQ_MASK, 1'h1, 32'h1);
      // Master rates 16 and 64, both idle levels, a collision each time
      for (int i = 0; i < 2; i++) begin
         ctl = {3'h1, i[0], i[0] ? `MODE_M64 : `MODE_M16};
         bus(`ADDR_CONTROL, 1'h1, {24'h0, ctl});
         repeat (2) @(negedge clock);
         cmp({31'h0, sckOut}, {31'h0, i[0]});
         b = 8'($urandom);
         peer.txByte = 8'($urandom);
         peer.start();
         bus(`ADDR_BUFFER, 1'h1, {24'h0, b});
         bus(`ADDR_BUFFER, 1'h1, {24'h0, ~b});
         waitHi(1'h1);
         cmp({24'h0, peer.rxByte}, {24'h0, b});
         cmp(peer.gapNs, i[0] ? 32'h500 : 32'h140);
         rd(`ADDR_BUFFER, {24'h0, peer.txByte});
         rd(`ADDR_CONTROL, {24'h0, 8'h80 | ctl});
         rd(`ADDR_IRQ_STATUS, 32'h3);
         bus(`ADDR_IRQ_STATUS, 1'h1, 32'h7);
         bus(`ADDR_CONTROL, 1'h1, 32'h0);
      end
      // Slave: second byte over unread buffer overflows and is lost
      bus(`ADDR_CONTROL, 1'h1, {24'h0, 4'h2, `MODE_SLAVE});
      bus(`ADDR_IRQ_MASK, 1'h1, 32'h4);
      b = 8'($urandom);
      peer.sendByte(b, 1'h1);
      peer.sendByte(~b, 1'h1);
      waitHi(1'h1);
      rd(`ADDR_CONTROL, 32'h65);
      rd(`ADDR_BUFFER, {24'h0, b});
      rd(`ADDR_IRQ_STATUS, 32'h5);
      bus(`ADDR_IRQ_MASK, 1'h1, 32'h0);
      @(negedge clock);
      cmp({31'h0, irq}, 32'h0);
      bus(`ADDR_IRQ_STATUS, 1'h1, 32'h7);
      rd(`ADDR_IRQ_STATUS, 32'h0);
      // Select-gated slave: a frame clocked with select high must leave no trace
      bus(`ADDR_CONTROL, 1'h1, {24'h0, 4'h2, `MODE_SLAVE_SS});
      bus(`ADDR_IRQ_MASK, 1'h1, 32'h1);
      b = 8'($urandom);
      peer.sendByte(~b, 1'h0);
      peer.sendByte(b, 1'h1);
      waitHi(1'h1);
      rd(`ADDR_BUFFER, {24'h0, b});
      rd(`ADDR_IRQ_STATUS, 32'h1);
      test_done();
   end
endmodule // sync_serial_spi_control_tb
`default_nettype wire
